// [design/pss_defines.svh]
`ifndef PSS_DEFINES_SVH
`define PSS_DEFINES_SVH

// register byte addresses
`define PSS_ADDR_CTL 16'h1C00
`define PSS_ADDR_STS 16'h1C01
`define PSS_ADDR_INT_STS 16'h1C02
`define PSS_ADDR_INT_EN 16'h1C03
`define PSS_ADDR_STATE 16'h1C04

// control register fields and reset value
`define PSS_CTL_FORCE 0
`define PSS_CTL_EN_N 1
`define PSS_CTL_RST 2'h0

// status register fields
`define PSS_STS_MAIN_RDY 5
`define PSS_STS_BUS_RDY 4
`define PSS_STS_PWR_RDY 2

// interrupt status / enable fields and reset values
`define PSS_INT_MAIN2BUS 5
`define PSS_INT_BUS2MAIN 4
`define PSS_INT_MAIN_LOST 3
`define PSS_INT_MAIN_RDY 2
`define PSS_INT_BUS_LOST 1
`define PSS_INT_BUS_RDY 0
`define PSS_INT_RST 6'h00

// fet vectors, bit0 A, bit1 B, bit2 C, bit3 D, one means shorted
`define PSS_FET_INIT 4'hA
`define PSS_FET_MAIN_STEP 4'h2
`define PSS_FET_MAIN 4'h3
`define PSS_FET_BUS_STEP 4'h8
`define PSS_FET_BUS 4'hC
`define PSS_FET_B2M_1 4'h8
`define PSS_FET_B2M_2 4'hA
`define PSS_FET_B2M_3 4'h2
`define PSS_FET_M2B_1 4'h2
`define PSS_FET_M2B_2 4'hA
`define PSS_FET_M2B_3 4'h8

// sequencing step time and clock rate
`define PSS_STEP_US 50
`define PSS_CLK_MHZ 100

`endif

// [design/pss_pkg.sv]
package pss_pkg;

   // switch sequencer states
   typedef enum logic [3:0] {
      ST_INIT,
      ST_MAIN_STEP,
      ST_MAIN,
      ST_BUS_STEP,
      ST_BUS,
      ST_B2M_1,
      ST_B2M_2,
      ST_B2M_3,
      ST_M2B_1,
      ST_M2B_2,
      ST_M2B_3
   } pss_state_t;

   // whole state of the sequencer, rail bits: 0 bus, 1 main, 2 core
   typedef struct packed {
      logic [2:0] sync1;
      logic [2:0] sync2;
      logic prev_bus;
      logic prev_main;
      pss_state_t state;
      logic [15:0] timer;
      logic [1:0] ctl;
      logic [5:0] int_sts;
      logic [5:0] int_en;
      logic [3:0] fet;
      logic hold_rst;
      logic irq;
      logic wake;
      logic [7:0] rdata;
   } pss_regs_t;

endpackage

// [design/pss_top.sv]
// Behaviour
// R1: hold the part in reset while core supply good is low.
// R2: hold in reset when neither bus nor main rail is good.
// R3: at power up keep A and C open, B and D shorted.
// R4: main rail only: open D, then short A after 50us.
// R5: bus rail only: bring up bus path and start normal operation.
// R6: on bus power, main rail good appears: open C first.
// R7: short B 50us after C opened.
// R8: open D 50us after B shorted.
// R9: short A 50us after D opened, main now feeds the core.
// R10: main is source and bus comes up: leave every fet alone.
// R11: both rails, bus goes away: keep source, flag bus status change.
// R12: both rails, main goes away: open A first.
// R13: close the bypass fet D 50us after A opened.
// R14: open B 50us after that.
// R15: short C 50us after B opened, core fed from bus rail.
// R16: both rails select main unless force bit set, which stops auto switching.
// R17: force bit (bit 0, reset 0) acts only on main with bus present.
// R18: interrupt output stays high until every asserted status bit is cleared.
// R19: each interrupt event is masked by its own enable bit.
// R20: any pending status bit raises the wake output.
// R21: control bit 1 is active low switch enable, reset 0.
// R22: registers live at 1C00h to 1C04h, above that reserved.
// R23: status bits clear on writing one, zero writes ignored.
// R24: bus lost bit sets when bus ready falls.
// R25: time steps with a counter, synchronise comparator inputs first.
// R26: interrupt is the OR of enabled status bits.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`include "pss_defines.svh"

module pss_top #(
   parameter int STEP_CYCLES = `PSS_STEP_US * `PSS_CLK_MHZ
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // comparator indications, asynchronous
   input wire logic i_bus_rail_good,
   input wire logic i_main_rail_good,
   input wire logic i_core_supply_good,
   // register port
   input wire logic [15:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // switch drives, high means fet shorted
   output logic o_fet_a,
   output logic o_fet_b,
   output logic o_fet_c,
   output logic o_fet_d,
   // system outputs
   output logic o_hold_reset,
   output logic o_irq,
   output logic o_wake
);

   localparam logic [15:0] STEP_LAST = 16'(STEP_CYCLES - 1);

   pss_pkg::pss_regs_t r;
   pss_pkg::pss_regs_t nxt;
   logic bus_ok;
   logic main_ok;
   logic core_ok;
   logic step_st;
   logic step_done;
   logic [5:0] set_vec;

   ////////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      nxt = r;
      set_vec = 6'h00;
      // R25: two flop synchroniser
      nxt.sync1 = {i_core_supply_good, i_main_rail_good, i_bus_rail_good};
      nxt.sync2 = r.sync1;
      bus_ok = r.sync2[0];
      main_ok = r.sync2[1];
      core_ok = r.sync2[2];
      nxt.prev_bus = bus_ok;
      nxt.prev_main = main_ok;
      step_st = (r.state != pss_pkg::ST_INIT) && (r.state != pss_pkg::ST_MAIN) &&
                (r.state != pss_pkg::ST_BUS);
      // R25: step timer
      step_done = (r.timer == STEP_LAST);

      // rail edge events
      // R24: bus lost on falling ready
      set_vec[`PSS_INT_BUS_LOST] = r.prev_bus && !bus_ok;
      set_vec[`PSS_INT_BUS_RDY] = !r.prev_bus && bus_ok;
      set_vec[`PSS_INT_MAIN_LOST] = r.prev_main && !main_ok;
      set_vec[`PSS_INT_MAIN_RDY] = !r.prev_main && main_ok;

      // sequencer, frozen while the switch is disabled unless both rails are lost, which forces ST_INIT
      // R21: enable is active low
      if (!bus_ok && !main_ok) begin
         nxt.state = pss_pkg::ST_INIT;
      end else if (!r.ctl[`PSS_CTL_EN_N]) begin
         unique case (r.state)
            pss_pkg::ST_INIT: begin
               // R4: main first opens D
               if (main_ok) begin
                  nxt.state = pss_pkg::ST_MAIN_STEP;
               // R5: bus only bring up
               end else begin
                  nxt.state = pss_pkg::ST_BUS_STEP;
               end
            end
            pss_pkg::ST_MAIN_STEP: begin
               if (step_done) begin
                  nxt.state = pss_pkg::ST_MAIN;
               end
            end
            pss_pkg::ST_BUS_STEP: begin
               if (step_done) begin
                  nxt.state = pss_pkg::ST_BUS;
               end
            end
            pss_pkg::ST_MAIN: begin
               // R12: main lost starts handover
               // R17: force only on main with bus present
               // without the bus neither cause may leave main
               if (bus_ok && (!main_ok || r.ctl[`PSS_CTL_FORCE])) begin
                  nxt.state = pss_pkg::ST_M2B_1;
               end
            end
            pss_pkg::ST_BUS: begin
               // R6: main appears, auto switch unless forced
               // R16: force bit blocks auto switching
               if (main_ok && !r.ctl[`PSS_CTL_FORCE]) begin
                  nxt.state = pss_pkg::ST_B2M_1;
               end
            end
            pss_pkg::ST_B2M_1: begin
               if (step_done) begin
                  nxt.state = pss_pkg::ST_B2M_2;
               end
            end
            pss_pkg::ST_B2M_2: begin
               if (step_done) begin
                  nxt.state = pss_pkg::ST_B2M_3;
               end
            end
            pss_pkg::ST_B2M_3: begin
               if (step_done) begin
                  nxt.state = pss_pkg::ST_MAIN;
                  set_vec[`PSS_INT_BUS2MAIN] = 1'b1;
               end
            end
            pss_pkg::ST_M2B_1: begin
               if (step_done) begin
                  nxt.state = pss_pkg::ST_M2B_2;
               end
            end
            pss_pkg::ST_M2B_2: begin
               if (step_done) begin
                  nxt.state = pss_pkg::ST_M2B_3;
               end
            end
            pss_pkg::ST_M2B_3: begin
               if (step_done) begin
                  nxt.state = pss_pkg::ST_BUS;
                  set_vec[`PSS_INT_MAIN2BUS] = 1'b1;
               end
            end
            default: begin
               nxt.state = pss_pkg::ST_INIT;
            end
         endcase
      end

      // timer restarts on every state change
      if (nxt.state != r.state) begin
         nxt.timer = 16'h0000;
      end else if (step_st && !step_done && !r.ctl[`PSS_CTL_EN_N]) begin
         nxt.timer = r.timer + 16'h0001;
      end

      // fet vector follows the state
      unique case (nxt.state)
         // R3: power up configuration
         pss_pkg::ST_INIT: nxt.fet = `PSS_FET_INIT;
         pss_pkg::ST_MAIN_STEP: nxt.fet = `PSS_FET_MAIN_STEP;
         // R9: final main configuration
         // R10: main source untouched by bus
         pss_pkg::ST_MAIN: nxt.fet = `PSS_FET_MAIN;
         pss_pkg::ST_BUS_STEP: nxt.fet = `PSS_FET_BUS_STEP;
         // R15: final bus configuration
         pss_pkg::ST_BUS: nxt.fet = `PSS_FET_BUS;
         // R7: B shorted after C open
         pss_pkg::ST_B2M_1: nxt.fet = `PSS_FET_B2M_1;
         pss_pkg::ST_B2M_2: nxt.fet = `PSS_FET_B2M_2;
         // R8: D opened after B
         pss_pkg::ST_B2M_3: nxt.fet = `PSS_FET_B2M_3;
         // R13: bypass D closed after A open
         pss_pkg::ST_M2B_1: nxt.fet = `PSS_FET_M2B_1;
         pss_pkg::ST_M2B_2: nxt.fet = `PSS_FET_M2B_2;
         // R14: B opened after bypass
         pss_pkg::ST_M2B_3: nxt.fet = `PSS_FET_M2B_3;
         default: nxt.fet = `PSS_FET_INIT;
      endcase

      // register writes
      // R22: decode of the three writable registers
      if (i_wr) begin
         unique case (i_addr)
            `PSS_ADDR_CTL: nxt.ctl = i_wdata[1:0];
            // R23: write one to clear
            `PSS_ADDR_INT_STS: nxt.int_sts = r.int_sts & ~i_wdata[5:0];
            `PSS_ADDR_INT_EN: nxt.int_en = i_wdata[5:0];
            default: nxt.ctl = r.ctl;
         endcase
      end
      // R11: event set wins over clear
      nxt.int_sts = nxt.int_sts | set_vec;

      // register reads, data valid one cycle later only
      nxt.rdata = 8'h00;
      if (i_rd) begin
         unique case (i_addr)
            `PSS_ADDR_CTL: nxt.rdata = {6'h00, r.ctl};
            `PSS_ADDR_STS: nxt.rdata = {2'h0, main_ok, bus_ok, 1'b0, core_ok, 2'h0};
            `PSS_ADDR_INT_STS: nxt.rdata = {2'h0, r.int_sts};
            `PSS_ADDR_INT_EN: nxt.rdata = {2'h0, r.int_en};
            `PSS_ADDR_STATE: nxt.rdata = {6'h00, r.fet[2], r.fet[0]};
            default: nxt.rdata = 8'h00;
         endcase
      end

      // R1: reset hold on core supply
      // R2: reset hold with no rail
      nxt.hold_rst = !core_ok || (!bus_ok && !main_ok);
      // R26: enabled status OR
      // R19: per bit mask
      // R18: level held until status cleared
      nxt.irq = |(nxt.int_sts & nxt.int_en);
      // R20: wake from any pending status
      nxt.wake = |nxt.int_sts;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         r <= '0;
         r.state <= pss_pkg::ST_INIT;
         r.ctl <= `PSS_CTL_RST;
         r.int_sts <= `PSS_INT_RST;
         r.int_en <= `PSS_INT_RST;
         r.fet <= `PSS_FET_INIT;
         r.hold_rst <= 1'b1;
      end else begin
         r <= nxt;
      end
   end

   // outputs straight from flops
   assign o_rdata = r.rdata;
   assign o_fet_a = r.fet[0];
   assign o_fet_b = r.fet[1];
   assign o_fet_c = r.fet[2];
   assign o_fet_d = r.fet[3];
   assign o_hold_reset = r.hold_rst;
   assign o_irq = r.irq;
   assign o_wake = r.wake;

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   a_hold_core: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R1
      !r.sync2[2] |=> o_hold_reset) else $error("reset not held on core loss");

   a_hold_norail: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R2
      (!r.sync2[0] && !r.sync2[1]) |=> o_hold_reset && r.state == pss_pkg::ST_INIT)
      else $error("reset not held without rails");

   a_init_fets: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R3
      r.state == pss_pkg::ST_INIT |-> !o_fet_a && o_fet_b && !o_fet_c && o_fet_d)
      else $error("power up fet state wrong");

   a_main_only: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R4
      (r.state == pss_pkg::ST_INIT && r.sync2[1] && !r.ctl[1])
      |=> !o_fet_d && !o_fet_a && r.state == pss_pkg::ST_MAIN_STEP)
      else $error("main only sequence wrong");

   a_main_short: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R4
      (r.state == pss_pkg::ST_MAIN_STEP && r.timer == STEP_LAST && !r.ctl[1] &&
      (r.sync2[0] || r.sync2[1])) |=> o_fet_a && !o_fet_d)
      else $error("main only step did not short A");

   a_b2m_seq: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R6
      (r.state == pss_pkg::ST_BUS && r.sync2[1] && r.sync2[0] && r.ctl == 2'h0)
      |=> !o_fet_c && !o_fet_b && o_fet_d) else $error("handover to main did not open C");

   a_b2m_short: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R7
      $rose(r.state == pss_pkg::ST_B2M_2) |-> o_fet_b && !o_fet_c && o_fet_d)
      else $error("B not shorted after C opened");

   a_b2m_done: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R9
      ($fell(r.state == pss_pkg::ST_B2M_3) && r.state == pss_pkg::ST_MAIN)
      |-> o_fet_a && o_fet_b && !o_fet_c && !o_fet_d) else $error("A not shorted at end");

   a_m2b_bypass: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R13
      $rose(r.state == pss_pkg::ST_M2B_2) |-> !o_fet_a && o_fet_d)
      else $error("bypass D not closed");

   a_b2m_steps: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R8
      $rose(r.state == pss_pkg::ST_B2M_3) |-> o_fet_b && !o_fet_d && $past(o_fet_d))
      else $error("D not opened after B");

   a_main_keep: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R10
      (r.state == pss_pkg::ST_MAIN && r.sync2[1] && !r.ctl[0]) |=> $stable(r.fet))
      else $error("fets moved while on main");

   a_m2b_start: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R12
      (r.state == pss_pkg::ST_MAIN && !r.sync2[1] && r.sync2[0] && !r.ctl[1])
      |=> !o_fet_a && o_fet_b && !o_fet_c && !o_fet_d)
      else $error("main loss did not open A");

   a_force_bus: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R16
      (r.state == pss_pkg::ST_BUS && r.ctl[0] && !r.ctl[1] && r.sync2[0]) |=>
      r.state == pss_pkg::ST_BUS) else $error("forced bus source left");

   a_force_nobus: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R17
      (r.state == pss_pkg::ST_MAIN && r.ctl == 2'h1 && r.sync2[1] && !r.sync2[0]) |=>
      r.state == pss_pkg::ST_MAIN) else $error("force acted without bus");

   a_step_time: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R25
      (step_st && nxt.state != r.state && nxt.state != pss_pkg::ST_INIT)
      |-> r.timer == STEP_LAST) else $error("step advanced early");

   a_bus_lost: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R24
      (r.prev_bus && !r.sync2[0]) |=> r.int_sts[1]) else $error("bus lost not flagged");

   a_w1c_clear: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R23
      (i_wr && i_addr == `PSS_ADDR_INT_STS && i_wdata[5:0] == 6'h3F && set_vec == 6'h00)
      |=> r.int_sts == 6'h00 && !o_irq) else $error("write one clear failed");

   a_irq_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R18
      (o_irq && !(i_wr && (i_addr == `PSS_ADDR_INT_STS || i_addr == `PSS_ADDR_INT_EN)))
      |=> o_irq)
      else $error("interrupt dropped without clear");

   a_irq_or: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R26
      o_irq == |(r.int_sts & r.int_en)) else $error("interrupt not masked OR");

   a_wake_any: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R20
      $rose(|r.int_sts) |-> o_wake) else $error("wake missing");

   a_rd_data: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R22
      (i_rd && i_addr == `PSS_ADDR_INT_EN) |=> o_rdata == {2'h0, $past(r.int_en)})
      else $error("read data wrong");

endmodule

// [verification/pss_rail_model.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module pss_rail_model (
   // clock
   input wire logic i_clk,
   // commanded rails, bit 0 bus, bit 1 main, bit 2 core
   input wire logic [2:0] i_cmd,
   input wire logic i_slow,
   // comparator outputs
   output logic [2:0] o_good
);
   logic [2:0] dly_ff [0:5];

   // a slowly ramping rail trips its comparator several cycles late
   always_ff @(posedge i_clk) begin
      dly_ff[0] <= i_cmd;
      for (int k = 1; k < 6; k++) begin
         dly_ff[k] <= dly_ff[k-1];
      end
   end

   // prompt or late comparator levels
   assign o_good = i_slow ? dly_ff[5] : i_cmd;
endmodule

// [verification/tb_top.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module tb_top;
   localparam int STEP = 8;
   logic i_clk, i_sys_rst, i_wr, i_rd, slow;
   logic [2:0] cmd, good;
   logic [15:0] i_addr;
   logic [7:0] i_wdata, o_rdata;
   logic o_fet_a, o_fet_b, o_fet_c, o_fet_d, o_hold_reset, o_irq, o_wake;
   logic [3:0] fets;
   int failures, n_compared, cycles;

   // fet levels in order a b c d
   assign fets = {o_fet_a, o_fet_b, o_fet_c, o_fet_d};

   // device with a short sequencing step
   pss_top #(.STEP_CYCLES(STEP)) pss_top_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .i_bus_rail_good(good[0]), .i_main_rail_good(good[1]), .i_core_supply_good(good[2]),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .o_fet_a(o_fet_a), .o_fet_b(o_fet_b), .o_fet_c(o_fet_c), .o_fet_d(o_fet_d),
      .o_hold_reset(o_hold_reset), .o_irq(o_irq), .o_wake(o_wake));

   // supplies and comparators
   pss_rail_model pss_rail_model_inst (.i_clk(i_clk), .i_cmd(cmd), .i_slow(slow),
      .o_good(good));

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask

   task automatic rails(input logic [2:0] v, input logic s);
      @(posedge i_clk);
      cmd <= v;
      slow <= s;
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      check(o_rdata, e);
   endtask

   // each fet pattern in turn, later ones exactly one step apart
   task automatic watch(input logic [15:0] seq, input int n);
      int t;
      for (int k = 0; k < n; k++) begin
         t = 0;
         do begin
            @(posedge i_clk);
            #1;
            t++;
         end while (fets !== seq[15-4*k -: 4] && t < 40);
         check(fets, seq[15-4*k -: 4]);
         if (k > 0) begin
            check(t, STEP);
         end
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // clock
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   // hang guard
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         conclude();
      end
   end

   // main sequence
   initial begin
      i_sys_rst = 1'b1;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = 16'h0000;
      i_wdata = 8'h00;
      cmd = 3'h0;
      slow = 1'b0;
      repeat (5) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      idle(1);
      // reset state and unmapped places
      check(fets, 4'h5);
      check(o_hold_reset, 1'b1);
      rd(16'h1C00, 8'h00);
      rd(16'h1C03, 8'h00);
      wr(16'h1C05, 8'hFF);
      rd(16'h1C05, 8'h00);
      wr(16'h1C01, 8'hFF);
      rd(16'h1C01, 8'h00);
      // core good alone still holds reset
      rails(3'h4, 1'b0);
      idle(6);
      check(o_hold_reset, 1'b1);
      // main rail only
      rails(3'h6, 1'b0);
      watch(16'h4C00, 2);
      check(o_hold_reset, 1'b0);
      rd(16'h1C01, 8'h24);
      rd(16'h1C04, 8'h01);
      check(o_wake, 1'b1);
      check(o_irq, 1'b0);
      wr(16'h1C03, 8'h04);
      idle(2);
      check(o_irq, 1'b1);
      // force without the bus must leave main in charge
      wr(16'h1C00, 8'h01);
      idle(20);
      check(fets, 4'hC);
      wr(16'h1C00, 8'h00);
      // bus comes and goes while main feeds the core
      rails(3'h7, 1'b0);
      idle(20);
      check(fets, 4'hC);
      rails(3'h6, 1'b0);
      idle(20);
      check(fets, 4'hC);
      rd(16'h1C02, 8'h07);
      wr(16'h1C02, 8'h00);
      rd(16'h1C02, 8'h07);
      wr(16'h1C03, 8'h3F);
      wr(16'h1C02, 8'h05);
      idle(2);
      check(o_irq, 1'b1);
      wr(16'h1C02, 8'h02);
      idle(2);
      check(o_irq, 1'b0);
      check(o_wake, 1'b0);
      rd(16'h1C03, 8'h3F);
      // main lost with bus present
      rails(3'h7, 1'b0);
      idle(10);
      rails(3'h5, 1'b0);
      watch(16'h4513, 4);
      idle(2);
      rd(16'h1C02, 8'h29);
      rd(16'h1C04, 8'h02);
      wr(16'h1C02, 8'hFF);
      // main returns through a late comparator
      rails(3'h7, 1'b1);
      watch(16'h154C, 4);
      idle(2);
      rd(16'h1C02, 8'h14);
      wr(16'h1C02, 8'hFF);
      rails(3'h7, 1'b0);
      // software forces the bus source
      wr(16'h1C00, 8'h01);
      watch(16'h4513, 4);
      idle(2);
      rd(16'h1C02, 8'h20);
      check(o_irq, 1'b1);
      // disabled switch stays frozen, then resumes automatic choice
      wr(16'h1C00, 8'h02);
      idle(30);
      check(fets, 4'h3);
      rd(16'h1C00, 8'h02);
      wr(16'h1C00, 8'h00);
      watch(16'h154C, 4);
      // core good lost, then both rails lost
      rails(3'h3, 1'b0);
      idle(6);
      check(o_hold_reset, 1'b1);
      rails(3'h4, 1'b0);
      idle(6);
      check(fets, 4'h5);
      check(o_hold_reset, 1'b1);
      conclude();
   end
endmodule
